// >>> hw/fault_map.svh
// constants of the led fault supervisor: timing, counts, reset values
// assumes a 100 MHz control clock and a pwm period tick from the dimming logic
`ifndef FAULT_MAP_SVH
`define FAULT_MAP_SVH
`define CHAN_COUNT 6
`define FLT_TIMEOUT_PWM 6
`define TIMER_W 4
`define CLK_PERIOD_NS 10
`define NS_PER_MS 1000000
`define STARTUP_DELAY_MS 31
`define STARTUP_W 22
`define STEP_W 3
`define FOLD_LAST_STEP 7
`define STEP_RESET 3'h0
`define STATUS_RESET 8'h00
`endif

// >>> hw/fault_pkg.sv
// types of the led fault supervisor: states, pin bundle, status byte
// assumes fault_map.svh sits on the include path
`include "fault_map.svh"
package fault_pkg;
  typedef logic [`CHAN_COUNT-1:0] chan_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_LOCKOUT, ST_PRECHARGE, ST_RUN, ST_THERM_OFF, ST_SHUTDOWN
  } sup_state_e;

  // comparator outputs arriving from the analog side
  typedef struct packed {
    logic supply_low;
    logic enable;
    logic sw_over_limit;
    logic lx_above_start;
    logic ovp_above_frac;
    logic ovp_limit;
    logic temp_lower;
    logic temp_upper;
    chan_t below_target;
    chan_t sink_above_short;
  } pin_s;

  // fault and status byte, bit 0 first from the right
  typedef struct packed {
    logic [1:0] rsvd;
    logic two_chan_off;
    logic one_chan_off;
    logic backlight_on;
    logic over_current;
    logic thermal;
    logic any_fault;
  } status_s;
endpackage : fault_pkg

// >>> hw/chan_timer.sv
// per channel fault timeout counted in pwm periods
// assumes tick_i is a one cycle pulse per pwm period, same clock
`timescale 1ns/1ps
`include "fault_map.svh"
module chan_timer #(
  parameter logic [`TIMER_W-1:0] TIMEOUT = `TIMER_W'(`FLT_TIMEOUT_PWM)
) (
  input wire logic clk_i, // control clock
  input wire logic clr_i, // synchronous clear
  input wire logic cond_i, // fault condition present
  input wire logic tick_i, // pwm period boundary
  output logic tripped_o // channel disabled
);
  logic [`TIMER_W-1:0] cnt_reg;
  logic tripped_reg;
  wire logic last_tick = tick_i && (cnt_reg == TIMEOUT - `TIMER_W'(1));

  // counts ticks while the fault holds, restarts when it clears
  always_ff @(posedge clk_i) begin
    if (clr_i) begin
      cnt_reg <= '0;
      tripped_reg <= 1'b0;
    end else if (!tripped_reg) begin
      if (!cond_i) begin
        cnt_reg <= '0;
      end else if (last_tick) begin
        tripped_reg <= 1'b1;
      end else if (tick_i) begin
        cnt_reg <= cnt_reg + `TIMER_W'(1);
      end
    end
  end

  assign tripped_o = tripped_reg;

  // ****************************************
  // checks
  // ****************************************
  property p_trip_late;
    @(posedge clk_i) disable iff (clr_i)
    $rose(tripped_reg) |-> $past(cnt_reg) == TIMEOUT - `TIMER_W'(1) && $past(tick_i);
  endproperty
  a_trip_late: assert property (p_trip_late) else $error("channel tripped early");

  property p_restart;
    @(posedge clk_i) disable iff (clr_i)
    !cond_i && !tripped_reg |=> cnt_reg == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("timeout not restarted");
endmodule : chan_timer

// >>> hw/led_fault_supervisor.sv
// fault supervision of a six channel led backlight driver
// assumes comparator pins are asynchronous; pwm tick, boost cycle start,
// host re-enable and channel mask come from logic on the same clock
//
// Contract
// - low supply halts boost, resets logic
// - restart after lockout only by host
// - switch off when current exceeds limit
// - start only after switch node passes threshold
// - output sense rise then fall: fet off
// - lower temp: low channels open, timed out
// - upper temp: boost and channels off
// - upper temp sets thermal status flag
// - logic and status stay alive in trip
// - channel below short level stays enabled
// - cool restart with stepwise reduced current
// - channel above short level off after six
// - open channel at overvoltage off after six
// - zener bypassed channel stays enabled
// - overvoltage: low channels off after six
// - output short: permanent shutdown after delay
// - channel faults shown in status byte
// - host masked channels never trip; only CHAN_FAULT_O hides earlier trips
`timescale 1ns/1ps
`include "fault_map.svh"
module led_fault_supervisor
  import fault_pkg::*;
#(
  parameter int unsigned STARTUP_CYCLES = `STARTUP_DELAY_MS * (`NS_PER_MS / `CLK_PERIOD_NS),
  parameter logic [`STEP_W-1:0] FOLD_LAST = `STEP_W'(`FOLD_LAST_STEP)
) (
  input wire logic REF_CLK_I, // 100 MHz control clock
  input wire logic RESETN_I, // synchronous reset, low
  input wire pin_s PINS_I, // asynchronous comparator pins
  input wire logic BOOST_CYCLE_I, // boost cycle start pulse
  input wire logic PWM_TICK_I, // pwm period boundary pulse
  input wire logic HOST_REENABLE_I, // host re-enable pulse
  input wire chan_t CHAN_MASK_I, // host channel mask, 1 = used
  output logic BOOST_SWITCH_O, // boost switch gate
  output logic TEST_CURRENT_O, // start-up test current on
  output logic INPUT_FET_O, // input protection fet on
  output chan_t CHAN_ENABLE_O, // channel sinks enabled
  output logic [`STEP_W-1:0] CURRENT_STEP_O, // foldback step, 0 = full
  output chan_t CHAN_FAULT_O, // channels faulted out
  output status_s STATUS_O // fault and status byte
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  pin_s meta_reg;
  pin_s pin_reg;

  // two stages before any logic looks at a pin
  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      meta_reg <= '0;
      pin_reg <= '0;
    end else begin
      meta_reg <= PINS_I;
      pin_reg <= meta_reg;
    end
  end

  // ****************************************
  // state and timers
  // ****************************************
  sup_state_e state_reg;
  sup_state_e state_next;
  logic [`STARTUP_W-1:0] su_cnt_reg;
  logic su_done_reg;
  logic ovp_armed_reg;
  logic short_reg;
  logic fet_reg;
  logic thermal_reg;
  logic [`STEP_W-1:0] step_reg;
  logic boost_reg;
  logic test_reg;
  chan_t good_reg;
  chan_t chan_en_reg;
  chan_t fault_reg;
  status_s status_reg;
  chan_t tripped;
  chan_t chan_cond;

  localparam logic [`STARTUP_W-1:0] SU_LAST = `STARTUP_W'(STARTUP_CYCLES - 1);

  // lockout returns everything below, except the state register and the status byte, to its reset value
  wire logic clr = !RESETN_I || state_reg == ST_LOCKOUT;
  wire logic in_run = state_reg == ST_RUN;
  wire logic in_pre = state_reg == ST_PRECHARGE;
  wire logic in_shut = state_reg == ST_SHUTDOWN;
  wire logic ovp_fall = ovp_armed_reg && !pin_reg.ovp_above_frac;
  wire logic lx_fail = in_pre && su_done_reg;
  wire logic short_due = su_done_reg && (short_reg || lx_fail);
  wire logic therm_entry = in_run && state_next == ST_THERM_OFF;
  wire logic any_trip = |tripped;
  wire logic multi_trip = $countones(tripped) > 1;

  // state transitions; lockout and shutdown take priority
  always_comb begin
    state_next = state_reg;
    if (!in_shut && pin_reg.supply_low) begin
      state_next = ST_LOCKOUT;
    end else if (!in_shut && state_reg != ST_LOCKOUT && !pin_reg.enable) begin
      state_next = ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (pin_reg.enable) begin
            state_next = ST_PRECHARGE;
          end
        end
        ST_LOCKOUT: begin
          if (HOST_REENABLE_I) begin
            state_next = ST_PRECHARGE;
          end
        end
        ST_PRECHARGE: begin
          if (short_due) begin
            state_next = ST_SHUTDOWN;
          end else if (pin_reg.lx_above_start) begin
            state_next = ST_RUN;
          end
        end
        ST_RUN: begin
          if (short_due) begin
            state_next = ST_SHUTDOWN;
          end else if (pin_reg.temp_upper) begin
            state_next = ST_THERM_OFF;
          end
        end
        ST_THERM_OFF: begin
          if (short_due) begin
            state_next = ST_SHUTDOWN;
          end else if (!pin_reg.temp_upper && !pin_reg.temp_lower) begin
            state_next = ST_RUN;
          end
        end
        default: begin
          state_next = ST_SHUTDOWN;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // start-up delay from power-up or re-enable, saturating
  always_ff @(posedge REF_CLK_I) begin
    if (clr) begin
      su_cnt_reg <= '0;
      su_done_reg <= 1'b0;
    end else if (!su_done_reg) begin
      su_cnt_reg <= su_cnt_reg + `STARTUP_W'(1);
      su_done_reg <= su_cnt_reg == SU_LAST;
    end
  end

  // output short tracking; the fet stays off once a fall is seen
  always_ff @(posedge REF_CLK_I) begin
    if (clr) begin
      ovp_armed_reg <= 1'b0;
      short_reg <= 1'b0;
      fet_reg <= 1'b1;
    end else begin
      if (pin_reg.ovp_above_frac) begin
        ovp_armed_reg <= 1'b1;
      end
      if (ovp_fall) begin
        short_reg <= 1'b1;
        fet_reg <= 1'b0;
      end else if (in_shut) begin
        fet_reg <= 1'b0;
      end
    end
  end

  // thermal flag is sticky; foldback step grows per upper trip
  always_ff @(posedge REF_CLK_I) begin
    if (clr) begin
      thermal_reg <= 1'b0;
      step_reg <= `STEP_RESET;
    end else begin
      if (pin_reg.temp_upper && (in_run || state_reg == ST_THERM_OFF)) begin
        thermal_reg <= 1'b1;
      end
      if (therm_entry && step_reg != FOLD_LAST) begin
        step_reg <= step_reg + `STEP_W'(1);
      end
    end
  end

  // ****************************************
  // boost switch and start-up test current
  // ****************************************
  // a cycle start turns the switch on unless the limit is already hit;
  // the sync lag adds two cycles to the cut-off, far below a switch period
  wire logic boost_next = in_run && (BOOST_CYCLE_I || boost_reg) && !pin_reg.sw_over_limit;

  always_ff @(posedge REF_CLK_I) begin
    if (clr) begin
      boost_reg <= 1'b0;
      test_reg <= 1'b0;
    end else begin
      boost_reg <= boost_next;
      test_reg <= in_pre;
    end
  end

  // ****************************************
  // channel supervision
  // ****************************************
  genvar ch;
  generate
    for (ch = 0; ch < `CHAN_COUNT; ch++) begin : g_chan
      // a channel is good once it reached its target current
      always_ff @(posedge REF_CLK_I) begin
        if (clr) begin
          good_reg[ch] <= 1'b0;
        end else if (in_run && CHAN_MASK_I[ch] && !pin_reg.below_target[ch]) begin
          good_reg[ch] <= 1'b1;
        end
      end
      // open: low current after good, at overvoltage or at lower temp;
      // a zener bypass keeps current up, so it never qualifies
      wire logic open_c = pin_reg.below_target[ch]
        && (good_reg[ch] || pin_reg.ovp_limit || pin_reg.temp_lower);
      // short: sink above threshold, only without an upper trip
      wire logic short_c = pin_reg.sink_above_short[ch] && !pin_reg.temp_upper;
      assign chan_cond[ch] = in_run && CHAN_MASK_I[ch] && (open_c || short_c);
      chan_timer #(
        .TIMEOUT(`TIMER_W'(`FLT_TIMEOUT_PWM))
      ) u_timer (
        .clk_i(REF_CLK_I),
        .clr_i(clr),
        .cond_i(chan_cond[ch]),
        .tick_i(PWM_TICK_I),
        .tripped_o(tripped[ch])
      );
    end
  endgenerate

  // channel enables in run: only a channel's own trip or its clear mask bit removes it
  always_ff @(posedge REF_CLK_I) begin
    if (clr) begin
      chan_en_reg <= '0;
      fault_reg <= '0;
    end else begin
      chan_en_reg <= in_run ? (CHAN_MASK_I & ~tripped) : '0;
      fault_reg <= tripped & CHAN_MASK_I;
    end
  end

  // ****************************************
  // status byte, kept alive through a thermal trip
  // ****************************************
  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      status_reg <= `STATUS_RESET;
    end else begin
      status_reg.rsvd <= 2'h0;
      status_reg.two_chan_off <= multi_trip;
      status_reg.one_chan_off <= any_trip && !multi_trip;
      status_reg.backlight_on <= in_run;
      status_reg.over_current <= short_reg;
      status_reg.thermal <= thermal_reg;
      status_reg.any_fault <= thermal_reg || short_reg || any_trip;
    end
  end

  assign BOOST_SWITCH_O = boost_reg;
  assign TEST_CURRENT_O = test_reg;
  assign INPUT_FET_O = fet_reg;
  assign CHAN_ENABLE_O = chan_en_reg;
  assign CURRENT_STEP_O = step_reg;
  assign CHAN_FAULT_O = fault_reg;
  assign STATUS_O = status_reg;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RESETN_I);

  property p_lockout;
    pin_reg.supply_low && !in_shut |=> state_reg == ST_LOCKOUT ##1 !BOOST_SWITCH_O;
  endproperty
  a_lockout: assert property (p_lockout) else $error("no lockout on low supply");

  property p_no_auto;
    state_reg == ST_LOCKOUT && !HOST_REENABLE_I |=> state_reg == ST_LOCKOUT;
  endproperty
  a_no_auto: assert property (p_no_auto) else $error("left lockout without host");

  property p_limit;
    pin_reg.sw_over_limit |=> !BOOST_SWITCH_O;
  endproperty
  a_limit: assert property (p_limit) else $error("switch on over limit");

  property p_start;
    in_run && $past(state_reg) == ST_PRECHARGE |-> $past(pin_reg.lx_above_start);
  endproperty
  a_start: assert property (p_start) else $error("started below threshold");

  property p_fet;
    ovp_fall && !clr && !pin_reg.supply_low |=> !INPUT_FET_O [*2];
  endproperty
  a_fet: assert property (p_fet) else $error("fet on after sense fall");

  property p_therm;
    in_run && pin_reg.temp_upper && !pin_reg.supply_low && pin_reg.enable && !short_due
    |=> state_reg == ST_THERM_OFF ##1 (!BOOST_SWITCH_O && CHAN_ENABLE_O == '0);
  endproperty
  a_therm: assert property (p_therm) else $error("outputs on in thermal trip");

  property p_flag;
    state_reg == ST_THERM_OFF |=> STATUS_O.thermal;
  endproperty
  a_flag: assert property (p_flag) else $error("thermal flag missing");

  property p_fold;
    therm_entry && step_reg != FOLD_LAST |=> step_reg == $past(step_reg) + `STEP_W'(1);
  endproperty
  a_fold: assert property (p_fold) else $error("foldback step not lowered");

  property p_shut;
    in_shut |-> su_done_reg ##1 in_shut && !INPUT_FET_O;
  endproperty
  a_shut: assert property (p_shut) else $error("shutdown early or left");

  property p_isolate;
    in_run ##1 in_run |-> CHAN_ENABLE_O == (CHAN_MASK_I & ~tripped) || $changed(tripped)
      || $changed(CHAN_MASK_I);
  endproperty
  a_isolate: assert property (p_isolate) else $error("healthy channel disabled");

  c_run: cover property (in_pre ##1 in_run);
  c_therm: cover property (state_reg == ST_THERM_OFF ##[1:50] in_run);
  c_trip: cover property ($rose(any_trip));
  c_reenable: cover property (state_reg == ST_LOCKOUT ##1 in_pre);
endmodule : led_fault_supervisor

// >>> bench/host_model.sv
// host side model: re-enable pulse and copy of the channel mask register
// assumes the supervisor's clock; drives 1 ns after the rising edge
`timescale 1ns/1ps
module host_model
  import fault_pkg::*;
(
  input wire logic clk_i, // control clock
  input wire status_s status_i, // fault and status byte
  output logic reenable_o, // re-enable pulse
  output chan_t mask_o // channels in use
);
  // ****************************************
  // host actions
  // ****************************************
  // power-up state: every channel in use, no pulse
  initial begin
    reenable_o = 1'b0;
    mask_o = 6'h3F;
  end

  // one cycle pulse; the device ignores it unless locked out
  task automatic reenable();
    @(posedge clk_i);
    #1 reenable_o = 1'b1;
    @(posedge clk_i);
    #1 reenable_o = 1'b0;
  endtask : reenable

  // clear bits to retire channels already known to be bad
  task automatic set_mask(input chan_t m);
    @(posedge clk_i);
    #1 mask_o = m;
  endtask : set_mask

  // the byte as a register read would return it
  function automatic status_s read_status();
    return status_i;
  endfunction : read_status
endmodule : host_model

// >>> bench/tb_top.sv
// self-checking bench of the led fault supervisor
// assumes host_model beside it; comparator pins driven as plain levels
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb_top
  import fault_pkg::*;
;
  // ****************************************
  // stimulus, instances
  // ****************************************
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  pin_s pins = '0;
  logic boost_cycle = 1'b0;
  logic pwm_tick = 1'b0;
  logic reenable;
  chan_t mask;
  logic boost_sw, test_cur, in_fet;
  chan_t chan_en, chan_flt;
  logic [2:0] step;
  status_s status;
  int error_cnt = 0;
  int checks_done = 0;

  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  // short start-up count keeps the run brief
  led_fault_supervisor #(.STARTUP_CYCLES(40)) u_dut (
    .REF_CLK_I(ref_clk), .RESETN_I(resetn), .PINS_I(pins), .BOOST_CYCLE_I(boost_cycle),
    .PWM_TICK_I(pwm_tick), .HOST_REENABLE_I(reenable), .CHAN_MASK_I(mask),
    .BOOST_SWITCH_O(boost_sw), .TEST_CURRENT_O(test_cur), .INPUT_FET_O(in_fet),
    .CHAN_ENABLE_O(chan_en), .CURRENT_STEP_O(step), .CHAN_FAULT_O(chan_flt), .STATUS_O(status)
  );
  host_model u_host (.clk_i(ref_clk), .status_i(status), .reenable_o(reenable), .mask_o(mask));

  // ****************************************
  // helpers
  // ****************************************
  // inputs always move 1 ns after the edge, away from sampling
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  task automatic ticks(input int n);
    repeat (n) begin
      pwm_tick = 1'b1;
      cyc(1);
      pwm_tick = 1'b0;
      cyc(1);
    end
  endtask : ticks

  task automatic do_reset();
    resetn = 1'b0;
    cyc(3);
    resetn = 1'b1;
    cyc(1);
  endtask : do_reset

  task automatic results();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  // ****************************************
  // scenarios
  // ****************************************
  // reset values, then precharge held until switch node passes
  task automatic t_start();
    `CHK(in_fet, 1'b1);
    `CHK(status, 8'h00);
    pins.enable = 1'b1;
    cyc(6);
    `CHK(test_cur, 1'b1);
    `CHK(status.backlight_on, 1'b0);
    pins.lx_above_start = 1'b1;
    cyc(6);
    `CHK(status, 8'h08);
    `CHK(chan_en, 6'h3F);
  endtask : t_start

  // cut-off per boost cycle, next cycle starts afresh
  task automatic t_boost();
    boost_cycle = 1'b1;
    cyc(1);
    boost_cycle = 1'b0;
    cyc(1);
    `CHK(boost_sw, 1'b1);
    pins.sw_over_limit = 1'b1;
    cyc(4);
    `CHK(boost_sw, 1'b0);
    pins.sw_over_limit = 1'b0;
    cyc(3);
    boost_cycle = 1'b1;
    cyc(1);
    boost_cycle = 1'b0;
    cyc(1);
    `CHK(boost_sw, 1'b1);
  endtask : t_boost

  // broken count restarts; masked channel never reported
  task automatic t_short();
    u_host.set_mask(6'h2F);
    pins.sink_above_short = 6'h12;
    cyc(4);
    ticks(5);
    cyc(4);
    `CHK(chan_en[1], 1'b1);
    pins.sink_above_short[1] = 1'b0;
    cyc(4);
    pins.sink_above_short[1] = 1'b1;
    cyc(4);
    ticks(5);
    cyc(4);
    `CHK(chan_en[1], 1'b1);
    ticks(1);
    cyc(4);
    `CHK(chan_en[1], 1'b0);
    `CHK(chan_flt, 6'h02);
    `CHK(u_host.read_status(), 8'h19);
    `CHK(chan_en & 6'h09, 6'h09);
  endtask : t_short

  // overvoltage retires the channel below target
  task automatic t_ovp();
    pins.below_target[2] = 1'b1;
    pins.ovp_limit = 1'b1;
    cyc(4);
    ticks(6);
    cyc(4);
    `CHK(chan_flt, 6'h06);
    `CHK(status, 8'h29);
    `CHK(chan_en[0], 1'b1);
    pins.ovp_limit = 1'b0;
    pins.below_target[2] = 1'b0;
  endtask : t_ovp

  // two trips, each lowering the current one step
  task automatic t_therm();
    for (int i = 1; i <= 2; i++) begin
      pins.temp_upper = 1'b1;
      cyc(5);
      `CHK(boost_sw, 1'b0);
      `CHK(chan_en, 6'h00);
      `CHK(status.thermal, 1'b1);
      `CHK(status.two_chan_off, 1'b1);
      `CHK(step, 3'(i));
      pins.temp_upper = 1'b0;
      cyc(6);
      `CHK(chan_en & 6'h09, 6'h09);
    end
  endtask : t_therm

  // lower threshold classes a weak channel as open
  task automatic t_lower();
    pins.temp_lower = 1'b1;
    pins.below_target[5] = 1'b1;
    cyc(4);
    ticks(6);
    cyc(4);
    `CHK(chan_flt[5], 1'b1);
    `CHK(chan_en[0], 1'b1);
    pins.temp_lower = 1'b0;
    pins.below_target[5] = 1'b0;
  endtask : t_lower

  // lockout clears state; only the host brings it back;
  // channels never good are then judged by overvoltage and lower temp alone
  task automatic t_lockout();
    pins.sink_above_short = 6'h00;
    u_host.set_mask(6'h3F);
    pins.supply_low = 1'b1;
    cyc(6);
    `CHK(boost_sw, 1'b0);
    `CHK(chan_flt, 6'h00);
    `CHK(step, 3'h0);
    pins.supply_low = 1'b0;
    pins.below_target = 6'h0C;
    cyc(10);
    `CHK(status.backlight_on, 1'b0);
    u_host.reenable();
    cyc(8);
    `CHK(status.backlight_on, 1'b1);
    `CHK(chan_en, 6'h3F);
    ticks(6);
    cyc(4);
    `CHK(chan_en, 6'h3F);
    u_host.set_mask(6'h37);
    pins.ovp_limit = 1'b1;
    cyc(4);
    ticks(6);
    cyc(4);
    `CHK(chan_flt, 6'h04);
    `CHK(chan_en, 6'h33);
    pins.ovp_limit = 1'b0;
    u_host.set_mask(6'h3F);
    pins.temp_lower = 1'b1;
    cyc(4);
    ticks(6);
    cyc(4);
    `CHK(chan_flt, 6'h0C);
    pins.temp_lower = 1'b0;
    pins.below_target = 6'h00;
  endtask : t_lockout

  // sense dip trips the fet, start-up timer then latches shutdown
  task automatic t_dead();
    pins.lx_above_start = 1'b0;
    do_reset();
    cyc(4);
    pins.ovp_above_frac = 1'b1;
    cyc(4);
    pins.ovp_above_frac = 1'b0;
    cyc(5);
    `CHK(in_fet, 1'b0);
    `CHK(test_cur, 1'b1);
    cyc(50);
    `CHK(status.over_current, 1'b1);
    `CHK(test_cur, 1'b0);
    `CHK(chan_en, 6'h00);
    pins.lx_above_start = 1'b1;
    u_host.reenable();
    cyc(8);
    `CHK(status.backlight_on, 1'b0);
  endtask : t_dead

  // ****************************************
  // sequence, watchdog
  // ****************************************
  initial begin
    do_reset();
    t_start();
    t_boost();
    t_short();
    t_ovp();
    t_therm();
    t_lower();
    t_lockout();
    t_dead();
    results();
  end

  // whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    error_cnt++;
    results();
  end
endmodule : tb_top
